// ### verilog/line_maint_int_control.sv
// Purpose: Loopback, loss-of-signal, all-ones, excess-zero counting and interrupt control
// Assumes: Line inputs come from datapath logic on aclk; bit ticks mark one bit interval
// Notes: 8-bit registers in the low byte of each AXI4-Lite word
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - System local and remote loopbacks follow bits
// - Remote, analog, digital2 loopbacks follow own bits
// - Declare loss after 175 or 1544 intervals
// - Clear loss: level, density, short zero runs
// - Receive all ones on loss when enabled
// - Transmit all ones on loss when enabled
// - One violation per inject bit rising edge
// - Zero run limit 15 AMI, 8 B8ZS
// - Alternate definition: 80 AMI, B8ZS 8
// - Count zero runs only with field 01
// - Manual mode copies count on transfer edge
// - Auto mode copies count every second
// - Transfer bit ignored outside manual mode
// - Transmit termination decode, 1xx reserved
// - Receive termination 1xx selects external network
// - Driver fail and loss flags gated by enables
// - Event flags gated by individual enables
// - Counter overflow flag gated by enable
// - Flags stay set until written one
// - Line code select picks zero run limit
module line_maint_int_control import line_maint_pkg::*; #(
  parameter int unsigned REPORT_CYC = REPORT_CYCLES
) (
  input wire logic aclk, // 200 MHz clock
  input wire logic aresetn, // Synchronous reset
  input wire logic [11:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Byte enables
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [11:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic rx_bit_tick, // One receive bit interval
  input wire logic rx_data_in, // Received mark this interval
  input wire logic rx_level_low, // Level under declare threshold
  input wire logic rx_level_recovered, // Level above clear threshold
  input wire logic tx_bit_tick, // One transmit bit interval
  input wire logic tx_data_in, // Transmit bit
  input wire logic driver_fail_status, // Driver failure level
  input wire logic pulse_sum_event, // Pulse sum overflow pulse
  input wire logic tx_jitter_fifo_event, // Transmit jitter FIFO slip
  input wire logic rx_jitter_fifo_event, // Receive jitter FIFO slip
  input wire logic violation_event, // Received bipolar violation
  output logic system_local_loop_en, // Loopback enable
  output logic system_remote_loop_en, // Loopback enable
  output logic remote_loop_en, // Loopback enable
  output logic analog_loop_en, // Loopback enable
  output logic digital_loop2_en, // Loopback enable
  output logic signal_loss, // Loss of signal state
  output logic rx_data_out, // Receive bit after substitution
  output logic tx_data_out, // Transmit bit after substitution
  output logic tx_violation, // Send this bit as a violation
  output logic [3:0] tx_match_sel, // One-hot 75/120/100/110 ohm
  output logic [3:0] rx_match_sel, // One-hot 75/120/100/110 ohm
  output logic rx_external_match, // Internal matching bypassed
  output logic irq // Interrupt, active high
);

  typedef struct packed {
    logic aw_got;
    logic [11:0] aw_addr;
    logic w_got;
    logic [7:0] w_data;
    logic w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [7:0] rx_code;
    logic [7:0] loop;
    logic [7:0] maint;
    logic [7:0] cnt_ctl;
    logic [7:0] term;
    logic [7:0] line_ie;
    logic [7:0] event_ie;
    logic [7:0] line_is;
    logic [7:0] event_is;
    logic [15:0] cnt_hold;
    logic [15:0] err_cnt;
    logic [31:0] sec_cnt;
    logic los;
    logic [10:0] low_run;
    logic [6:0] win_cnt;
    logic [7:0] win_marks;
    logic [6:0] win_zrun;
    logic [6:0] win_zmax;
    logic [6:0] exz_run;
    logic inj_pending;
    logic rx_out;
    logic tx_out;
    logic tx_viol;
    logic df_prev;
  } st_t;

  st_t s_ff;
  st_t nxt_s;
  logic commit;
  logic xfer;
  logic cnt_inc;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [7:0] widx;
    logic [7:0] ridx;
    logic [7:0] line_clr;
    logic [7:0] ev_clr;
    logic [7:0] line_set;
    logic [7:0] ev_set;
    logic [10:0] los_thr;
    logic [6:0] exz_thr;
    logic [6:0] zr;
    logic [6:0] zm;
    logic [7:0] mk;
    logic exz_hit;
    los_thr = LOS_DECLARE_SHORT;
    exz_thr = ZRUN_B8ZS;
    exz_hit = 1'b0;
    widx = s_ff.aw_addr[9:2];
    ridx = s_axi_araddr[9:2];
    line_clr = 8'h00;
    ev_clr = 8'h00;
    line_set = 8'h00;
    ev_set = 8'h00;
    zr = 7'h00;
    zm = 7'h00;
    mk = 8'h00;
    nxt_s = s_ff;
    xfer = 1'b0;
    // Write channel: address and data taken in either order
    if (s_axi_awvalid && !s_ff.aw_got) begin
      nxt_s.aw_got = 1'b1;
      nxt_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_ff.w_got) begin
      nxt_s.w_got = 1'b1;
      nxt_s.w_data = s_axi_wdata[7:0];
      nxt_s.w_strb = s_axi_wstrb[0];
    end
    if (s_ff.bvalid && s_axi_bready) begin
      nxt_s.bvalid = 1'b0;
    end
    commit = s_ff.aw_got && s_ff.w_got && !s_ff.bvalid;
    if (commit) begin
      nxt_s.aw_got = 1'b0;
      nxt_s.w_got = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = RESP_OKAY;
      if (s_ff.aw_addr[11:10] != 2'b00) begin
        nxt_s.bresp = RESP_SLVERR;
      end else if (s_ff.w_strb) begin
        case (widx)
          IDX_RX_CODE: nxt_s.rx_code = s_ff.w_data & RX_CODE_MASK;
          IDX_LOOP: nxt_s.loop = s_ff.w_data & LOOP_MASK;
          IDX_MAINT: nxt_s.maint = s_ff.w_data & MAINT_MASK;
          IDX_CNT_CTL: nxt_s.cnt_ctl = s_ff.w_data & CNT_CTL_MASK;
          IDX_TERM: nxt_s.term = s_ff.w_data & TERM_MASK;
          IDX_LINE_IE: nxt_s.line_ie = s_ff.w_data & LINE_MASK;
          IDX_EVENT_IE: nxt_s.event_ie = s_ff.w_data & EVENT_MASK;
          IDX_LINE_IS: line_clr = s_ff.w_data & LINE_MASK;
          IDX_EVENT_IS: ev_clr = s_ff.w_data & EVENT_MASK;
          IDX_LINE_STAT, IDX_CNT_HI, IDX_CNT_LO: nxt_s.bresp = RESP_OKAY;
          default: nxt_s.bresp = RESP_SLVERR;
        endcase
      end
    end
    // Edges are seen at the write itself, so holding the bit high does nothing more
    if (commit && s_ff.w_strb && widx == IDX_CNT_CTL && s_ff.aw_addr[11:10] == 2'b00) begin
      if (s_ff.w_data[B_INJECT] && !s_ff.cnt_ctl[B_INJECT]) begin
        nxt_s.inj_pending = 1'b1;
      end
      if (s_ff.w_data[B_TRANSFER] && !s_ff.cnt_ctl[B_TRANSFER] && !s_ff.cnt_ctl[B_MODE]) begin
        xfer = 1'b1;
      end
    end
    // Read channel: data stands one cycle after the address is taken
    if (s_ff.rvalid && s_axi_rready) begin
      nxt_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_ff.rvalid) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp = RESP_OKAY;
      nxt_s.rdata = 8'h00;
      if (s_axi_araddr[11:10] != 2'b00) begin
        nxt_s.rresp = RESP_SLVERR;
      end else begin
        case (ridx)
          IDX_RX_CODE: nxt_s.rdata = s_ff.rx_code;
          IDX_LOOP: nxt_s.rdata = s_ff.loop;
          IDX_MAINT: nxt_s.rdata = s_ff.maint;
          IDX_CNT_CTL: nxt_s.rdata = s_ff.cnt_ctl;
          IDX_TERM: nxt_s.rdata = s_ff.term;
          IDX_LINE_IE: nxt_s.rdata = s_ff.line_ie;
          IDX_EVENT_IE: nxt_s.rdata = s_ff.event_ie;
          IDX_LINE_STAT: nxt_s.rdata = {5'h00, s_ff.df_prev, 1'b0, s_ff.los};
          IDX_LINE_IS: nxt_s.rdata = s_ff.line_is;
          IDX_EVENT_IS: nxt_s.rdata = s_ff.event_is;
          IDX_CNT_HI: nxt_s.rdata = s_ff.cnt_hold[15:8];
          IDX_CNT_LO: nxt_s.rdata = s_ff.cnt_hold[7:0];
          default: nxt_s.rresp = RESP_SLVERR;
        endcase
      end
    end

    // Loss of signal declare and clear
    los_thr = s_ff.maint[B_LOSS_CRIT] ? LOS_DECLARE_LONG : LOS_DECLARE_SHORT;
    if (rx_bit_tick && !s_ff.los) begin
      if (!rx_level_low) begin
        nxt_s.low_run = 11'h000;
      end else if (s_ff.low_run == los_thr - 11'd1) begin
        nxt_s.los = 1'b1;
        nxt_s.low_run = 11'h000;
        nxt_s.win_cnt = 7'h00;
        nxt_s.win_marks = 8'h00;
        nxt_s.win_zrun = 7'h00;
        nxt_s.win_zmax = 7'h00;
      end else begin
        nxt_s.low_run = s_ff.low_run + 11'd1;
      end
    end else if (rx_bit_tick) begin
      zr = rx_data_in ? 7'h00 : (s_ff.win_zrun == 7'h7f ? 7'h7f : s_ff.win_zrun + 7'd1);
      zm = (zr > s_ff.win_zmax) ? zr : s_ff.win_zmax;
      mk = s_ff.win_marks + {7'h00, rx_data_in};
      nxt_s.win_cnt = s_ff.win_cnt + 7'd1;
      nxt_s.win_marks = mk;
      nxt_s.win_zrun = zr;
      nxt_s.win_zmax = zm;
      // A weak level anywhere in the window restarts the whole judgement
      if (!rx_level_recovered || {1'b0, s_ff.win_cnt} == LOS_WINDOW - 8'd1) begin
        nxt_s.win_cnt = 7'h00;
        nxt_s.win_marks = 8'h00;
        nxt_s.win_zrun = 7'h00;
        nxt_s.win_zmax = 7'h00;
        if (rx_level_recovered && mk >= LOS_MIN_MARKS && zm < LOS_MAX_ZEROS) begin
          nxt_s.los = 1'b0;
        end
      end
    end

    // Receive and transmit substitution, violation injection
    if (rx_bit_tick) begin
      nxt_s.rx_out = (s_ff.los && s_ff.maint[B_RX_ONES]) ? 1'b1 : rx_data_in;
    end
    if (tx_bit_tick) begin
      nxt_s.tx_out = (s_ff.los && s_ff.maint[B_TX_ONES]) ? 1'b1 : tx_data_in;
      nxt_s.tx_viol = s_ff.inj_pending;
      nxt_s.inj_pending = nxt_s.inj_pending && !s_ff.inj_pending;
    end

    // Excess-zero detection, counting and reporting
    exz_thr = !s_ff.rx_code[0] ? ZRUN_B8ZS :
      (s_ff.cnt_ctl[B_ZERO_DEF] ? ZRUN_AMI_FCC : ZRUN_AMI_ANSI);
    exz_hit = rx_bit_tick && !rx_data_in && s_ff.exz_run == exz_thr;
    if (rx_bit_tick) begin
      nxt_s.exz_run = rx_data_in ? 7'h00 :
        (s_ff.exz_run == 7'h7f ? 7'h7f : s_ff.exz_run + 7'd1);
    end
    cnt_inc = exz_hit && s_ff.cnt_ctl[F_CNT_EN +: 2] == CNT_EN_CODE;
    if (cnt_inc) begin
      nxt_s.err_cnt = s_ff.err_cnt + 16'd1;
    end
    if (s_ff.cnt_ctl[B_MODE]) begin
      if (s_ff.sec_cnt == REPORT_CYC - 1) begin
        nxt_s.sec_cnt = 32'h0;
        xfer = 1'b1;
      end else begin
        nxt_s.sec_cnt = s_ff.sec_cnt + 32'd1;
      end
    end else begin
      nxt_s.sec_cnt = 32'h0;
    end
    if (xfer) begin
      nxt_s.cnt_hold = s_ff.err_cnt;
    end

    // Sticky flags; a set in the same cycle as a clear wins
    line_set[B_LOS] = nxt_s.los && !s_ff.los;
    line_set[B_DF] = driver_fail_status && !s_ff.df_prev;
    ev_set[B_CNTOV] = cnt_inc && s_ff.err_cnt == 16'hffff;
    ev_set[B_VIOL] = violation_event;
    ev_set[B_ZRUN] = exz_hit;
    ev_set[B_RXJ] = rx_jitter_fifo_event;
    ev_set[B_TXJ] = tx_jitter_fifo_event;
    ev_set[B_PSUM] = pulse_sum_event;
    nxt_s.df_prev = driver_fail_status;
    nxt_s.line_is = (s_ff.line_is & ~line_clr) | line_set;
    nxt_s.event_is = (s_ff.event_is & ~ev_clr) | ev_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= '0;
      s_ff.term <= TERM_RESET;
    end else begin
      s_ff <= nxt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign s_axi_awready = !s_ff.aw_got;
  assign s_axi_wready = !s_ff.w_got;
  assign s_axi_bvalid = s_ff.bvalid;
  assign s_axi_bresp = s_ff.bresp;
  assign s_axi_arready = !s_ff.rvalid;
  assign s_axi_rvalid = s_ff.rvalid;
  assign s_axi_rdata = {24'h000000, s_ff.rdata};
  assign s_axi_rresp = s_ff.rresp;
  assign system_local_loop_en = s_ff.loop[B_SYS_LOCAL];
  assign system_remote_loop_en = s_ff.loop[B_SYS_REMOTE];
  assign remote_loop_en = s_ff.loop[B_REMOTE];
  assign analog_loop_en = s_ff.loop[B_ANALOG];
  assign digital_loop2_en = s_ff.loop[B_DIG2];
  assign signal_loss = s_ff.los;
  assign rx_data_out = s_ff.rx_out;
  assign tx_data_out = s_ff.tx_out;
  assign tx_violation = s_ff.tx_viol;
  // Reserved transmit codes select no impedance at all
  assign tx_match_sel = s_ff.term[F_TX_TERM + 2] ? 4'h0 : 4'h1 << s_ff.term[F_TX_TERM +: 2];
  assign rx_match_sel = s_ff.term[F_RX_TERM + 2] ? 4'h0 : 4'h1 << s_ff.term[F_RX_TERM +: 2];
  assign rx_external_match = s_ff.term[F_RX_TERM + 2];
  assign irq = |(s_ff.line_is & s_ff.line_ie) || |(s_ff.event_is & s_ff.event_ie);

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [10:0] los_thr_chk;
  assign los_thr_chk = s_ff.maint[B_LOSS_CRIT] ? 11'd1544 : 11'd175;
  property p_declare;
    rx_bit_tick && !s_ff.los && rx_level_low && s_ff.low_run == los_thr_chk - 11'd1 |=> signal_loss;
  endproperty
  a_declare: assert property (p_declare) else $error("loss not declared at threshold");

  property p_rx_ones;
    rx_bit_tick && signal_loss && s_ff.maint[B_RX_ONES] |=> rx_data_out;
  endproperty
  a_rx_ones: assert property (p_rx_ones) else $error("receive ones not inserted");

  property p_tx_pass;
    tx_bit_tick && !(signal_loss && s_ff.maint[B_TX_ONES]) |=> tx_data_out == $past(tx_data_in);
  endproperty
  a_tx_pass: assert property (p_tx_pass) else $error("transmit data altered");

  property p_count;
    s_ff.err_cnt != $past(s_ff.err_cnt) |-> $past(s_ff.cnt_ctl[3:2]) == 2'b01;
  endproperty
  a_count: assert property (p_count) else $error("count moved while disabled");

  property p_manual;
    commit && !s_ff.cnt_ctl[B_MODE] && s_ff.aw_addr[9:2] == IDX_CNT_CTL && s_ff.w_strb
      && s_ff.w_data[0] && !s_ff.cnt_ctl[0] |=> s_ff.cnt_hold == $past(s_ff.err_cnt);
  endproperty
  a_manual: assert property (p_manual) else $error("manual transfer missed");

  property p_sticky;
    $fell(s_ff.line_is[B_LOS]) |-> $past(commit) && $past(s_ff.w_data[B_LOS]);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

  property p_irq_quiet;
    (s_ff.line_is & s_ff.line_ie) == 8'h00 && (s_ff.event_is & s_ff.event_ie) == 8'h00 |-> !irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt with no enabled flag");

  property p_irq_viol;
    violation_event && s_ff.event_ie[B_VIOL] |=> irq;
  endproperty
  a_irq_viol: assert property (p_irq_viol) else $error("violation interrupt missing");

  property p_irq_ovf;
    s_ff.event_is[B_CNTOV] && s_ff.event_ie[B_CNTOV] |-> irq;
  endproperty
  a_irq_ovf: assert property (p_irq_ovf) else $error("overflow interrupt missing");

  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");

endmodule

`default_nettype wire

// ### verilog/line_maint_pkg.sv
// Purpose: Constants for the line maintenance and interrupt control block
// Assumes: Register index N sits at byte address 4*N on AXI4-Lite
// Notes: Field positions are bit numbers inside each 8-bit register
package line_maint_pkg;
  // Register indices
  localparam logic [7:0] IDX_RX_CODE = 8'h28;
  localparam logic [7:0] IDX_LOOP = 8'h2b;
  localparam logic [7:0] IDX_MAINT = 8'h2c;
  localparam logic [7:0] IDX_CNT_CTL = 8'h31;
  localparam logic [7:0] IDX_TERM = 8'h32;
  localparam logic [7:0] IDX_LINE_IE = 8'h33;
  localparam logic [7:0] IDX_EVENT_IE = 8'h34;
  localparam logic [7:0] IDX_LINE_STAT = 8'h36;
  localparam logic [7:0] IDX_LINE_IS = 8'h3a;
  localparam logic [7:0] IDX_EVENT_IS = 8'h3b;
  localparam logic [7:0] IDX_CNT_HI = 8'h3c;
  localparam logic [7:0] IDX_CNT_LO = 8'h3d;
  // Writable bit masks
  localparam logic [7:0] RX_CODE_MASK = 8'h01;
  localparam logic [7:0] LOOP_MASK = 8'h37;
  localparam logic [7:0] MAINT_MASK = 8'h1c;
  localparam logic [7:0] CNT_CTL_MASK = 8'h5f;
  localparam logic [7:0] TERM_MASK = 8'h3f;
  localparam logic [7:0] LINE_MASK = 8'h05;
  localparam logic [7:0] EVENT_MASK = 8'h77;
  localparam logic [7:0] TERM_RESET = 8'h04;
  // Field positions
  localparam int B_DIG2 = 0;
  localparam int B_ANALOG = 1;
  localparam int B_REMOTE = 2;
  localparam int B_SYS_REMOTE = 4;
  localparam int B_SYS_LOCAL = 5;
  localparam int B_TX_ONES = 2;
  localparam int B_RX_ONES = 3;
  localparam int B_LOSS_CRIT = 4;
  localparam int B_TRANSFER = 0;
  localparam int B_MODE = 1;
  localparam int F_CNT_EN = 2;
  localparam int B_ZERO_DEF = 4;
  localparam int B_INJECT = 6;
  localparam int F_RX_TERM = 0;
  localparam int F_TX_TERM = 3;
  localparam int B_LOS = 0;
  localparam int B_DF = 2;
  localparam int B_CNTOV = 0;
  localparam int B_VIOL = 1;
  localparam int B_ZRUN = 2;
  localparam int B_RXJ = 4;
  localparam int B_TXJ = 5;
  localparam int B_PSUM = 6;
  // Line criteria, in bit intervals
  localparam logic [10:0] LOS_DECLARE_SHORT = 11'd175;
  localparam logic [10:0] LOS_DECLARE_LONG = 11'd1544;
  localparam logic [7:0] LOS_WINDOW = 8'd128;
  localparam logic [7:0] LOS_MIN_MARKS = 8'd16;
  localparam logic [6:0] LOS_MAX_ZEROS = 7'd100;
  localparam logic [6:0] ZRUN_B8ZS = 7'd8;
  localparam logic [6:0] ZRUN_AMI_ANSI = 7'd15;
  localparam logic [6:0] ZRUN_AMI_FCC = 7'd80;
  localparam logic [1:0] CNT_EN_CODE = 2'b01;
  // Auto report period
  localparam int REPORT_PERIOD_NS = 1000000000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int REPORT_CYCLES = REPORT_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ### tb/line_maint_int_control_bench.sv
// Purpose: Register-level bench for the line maintenance and interrupt control block
// Assumes: Line ticks and events are driven on aclk; outputs register on the same edge that takes a tick
// Notes: Auto report period cut to 50 cycles; the 16-bit counter overflow is not reached
`timescale 1ns/1ps
`default_nettype none
module line_maint_int_control_bench import line_maint_pkg::*;;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic rtick = 1'b0, rdat = 1'b0, rlow = 1'b0, rrec = 1'b0;
  logic ttick = 1'b0, tdat = 1'b0, dfail = 1'b0;
  logic [3:0] ev = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [4:0] loops;
  logic sloss, rxo, txo, tviol, rxext, irq;
  logic [3:0] txsel, rxsel, m;
  logic [7:0] evb [4] = '{8'h02, 8'h10, 8'h20, 8'h40};
  int fails = 0;
  int samples_checked = 0;

  always #2.5 aclk = ~aclk;

  line_maint_int_control #(.REPORT_CYC(50)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_bit_tick(rtick), .rx_data_in(rdat), .rx_level_low(rlow), .rx_level_recovered(rrec),
    .tx_bit_tick(ttick), .tx_data_in(tdat), .driver_fail_status(dfail),
    .pulse_sum_event(ev[3]), .tx_jitter_fifo_event(ev[2]), .rx_jitter_fifo_event(ev[1]),
    .violation_event(ev[0]),
    .system_local_loop_en(loops[4]), .system_remote_loop_en(loops[3]),
    .remote_loop_en(loops[2]), .analog_loop_en(loops[1]), .digital_loop2_en(loops[0]),
    .signal_loss(sloss), .rx_data_out(rxo), .tx_data_out(txo), .tx_violation(tviol),
    .tx_match_sel(txsel), .rx_match_sel(rxsel), .rx_external_match(rxext), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
      fails++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Address and data are offered together and each is dropped once taken
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    int n;
    logic aw_take, w_take, got;
    logic [1:0] resp;
    @(posedge aclk);
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {24'h000000, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    // Readies and response are sampled settled, then acted on at the next edge
    do begin
      @(negedge aclk);
      aw_take = awready;
      w_take = wready;
      got = bvalid;
      resp = bresp;
      @(posedge aclk);
      n++;
      if (aw_take) awvalid <= 1'b0;
      if (w_take) wvalid <= 1'b0;
    end while (!got && n < 64);
    bready <= 1'b0;
    if (n >= 64) begin
      fails++;
      test_done();
    end
    chk($sformatf("write response %h", idx), 32'(resp), 32'(er));
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] er = RESP_OKAY);
    int n;
    logic ar_take, got;
    logic [31:0] d;
    logic [1:0] resp;
    @(posedge aclk);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(negedge aclk);
      ar_take = arready;
      got = rvalid;
      d = rdata;
      resp = rresp;
      @(posedge aclk);
      n++;
      if (ar_take) arvalid <= 1'b0;
    end while (!got && n < 64);
    rready <= 1'b0;
    if (n >= 64) begin
      fails++;
      test_done();
    end
    chk($sformatf("register %h", idx), d, {24'h000000, exp});
    chk($sformatf("read response %h", idx), 32'(resp), 32'(er));
  endtask

  // Two settle cycles of margin: the output registers on the same edge that takes the tick
  task automatic rx(input logic d, input logic low, input logic rec);
    @(posedge aclk);
    rtick <= 1'b1;
    rdat <= d;
    rlow <= low;
    rrec <= rec;
    @(posedge aclk);
    rtick <= 1'b0;
    cyc(2);
  endtask

  task automatic tx(input logic d);
    @(posedge aclk);
    ttick <= 1'b1;
    tdat <= d;
    @(posedge aclk);
    ttick <= 1'b0;
    cyc(2);
  endtask

  task automatic lows(input int n);
    repeat (n) rx(1'b0, 1'b1, 1'b0);
  endtask

  // A mark first so each run starts from zero
  task automatic zrun(input int n);
    rx(1'b1, 1'b0, 1'b1);
    repeat (n) rx(1'b0, 1'b0, 1'b1);
  endtask

  task automatic note(input string nm);
    $display("test %s finished", nm);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(6);
    aresetn <= 1'b1;
    rd(IDX_TERM, TERM_RESET);
    chk("rx external", 32'(rxext), 32'h1);
    chk("tx match", 32'(txsel), 32'h1);
    rd(IDX_EVENT_IE, 8'h00);
    rd(8'h30, 8'h00, RESP_SLVERR);
    wr(8'h30, 8'hff, RESP_SLVERR);
    wr(IDX_LINE_STAT, 8'hff);
    rd(IDX_LINE_STAT, 8'h00);
    note("reset and map");
    wr(IDX_LOOP, 8'hff);
    rd(IDX_LOOP, LOOP_MASK);
    chk("loopbacks", 32'(loops), 32'h1f);
    wr(IDX_LOOP, 8'h22);
    chk("loopbacks", 32'(loops), 32'h12);
    wr(IDX_LOOP, 8'h14);
    chk("loopbacks", 32'(loops), 32'h0c);
    note("loopback");
    for (int c = 0; c < 6; c++) begin
      wr(IDX_TERM, {2'b00, c[2:0], c[2:0]});
      m = (c < 4) ? 4'(1 << c) : 4'h0;
      chk("tx match", 32'(txsel), 32'(m));
      chk("rx match", 32'(rxsel), 32'(m));
      chk("rx external", 32'(rxext), 32'(c[2]));
    end
    note("termination");
    dfail <= 1'b1;
    cyc(3);
    rd(IDX_LINE_STAT, 8'h04);
    rd(IDX_LINE_IS, 8'h04);
    chk("irq", 32'(irq), 32'h0);
    wr(IDX_LINE_IE, 8'h04);
    chk("irq", 32'(irq), 32'h1);
    wr(IDX_LINE_IS, 8'h04);
    chk("irq", 32'(irq), 32'h0);
    rd(IDX_LINE_IS, 8'h00);
    note("driver fail");
    wr(IDX_LINE_IE, 8'h01);
    wr(IDX_MAINT, 8'h0c);
    lows(174);
    chk("loss", 32'(sloss), 32'h0);
    lows(1);
    chk("loss", 32'(sloss), 32'h1);
    chk("irq", 32'(irq), 32'h1);
    rx(1'b0, 1'b1, 1'b0);
    tx(1'b0);
    chk("rx data", 32'(rxo), 32'h1);
    chk("tx data", 32'(txo), 32'h1);
    wr(IDX_LINE_IS, 8'h01);
    chk("irq", 32'(irq), 32'h0);
    wr(IDX_MAINT, 8'h10);
    rx(1'b0, 1'b1, 1'b0);
    tx(1'b0);
    chk("rx data", 32'(rxo), 32'h0);
    chk("tx data", 32'(txo), 32'h0);
    repeat (127) rx(1'b1, 1'b0, 1'b1);
    chk("loss", 32'(sloss), 32'h1);
    rx(1'b1, 1'b0, 1'b1);
    chk("loss", 32'(sloss), 32'h0);
    lows(1543);
    chk("loss", 32'(sloss), 32'h0);
    lows(1);
    chk("loss", 32'(sloss), 32'h1);
    repeat (128) rx(1'b1, 1'b0, 1'b1);
    chk("loss", 32'(sloss), 32'h0);
    chk("irq", 32'(irq), 32'h1);
    wr(IDX_LINE_IS, 8'h01);
    chk("irq", 32'(irq), 32'h0);
    note("signal loss");
    wr(IDX_RX_CODE, 8'h01);
    wr(IDX_CNT_CTL, 8'h04);
    wr(IDX_EVENT_IS, 8'hff);
    zrun(15);
    rd(IDX_EVENT_IS, 8'h00);
    rx(1'b0, 1'b0, 1'b1);
    rd(IDX_EVENT_IS, 8'h04);
    wr(IDX_EVENT_IE, 8'h04);
    chk("irq", 32'(irq), 32'h1);
    wr(IDX_EVENT_IS, 8'h04);
    chk("irq", 32'(irq), 32'h0);
    wr(IDX_CNT_CTL, 8'h05);
    rd(IDX_CNT_LO, 8'h01);
    rd(IDX_CNT_HI, 8'h00);
    wr(IDX_CNT_CTL, 8'h14);
    zrun(80);
    rd(IDX_EVENT_IS, 8'h00);
    rx(1'b0, 1'b0, 1'b1);
    rd(IDX_EVENT_IS, 8'h04);
    wr(IDX_RX_CODE, 8'h00);
    wr(IDX_EVENT_IS, 8'hff);
    zrun(8);
    rd(IDX_EVENT_IS, 8'h00);
    rx(1'b0, 1'b0, 1'b1);
    rd(IDX_EVENT_IS, 8'h04);
    wr(IDX_CNT_CTL, 8'h15);
    rd(IDX_CNT_LO, 8'h03);
    wr(IDX_CNT_CTL, 8'h0c);
    zrun(9);
    wr(IDX_CNT_CTL, 8'h00);
    wr(IDX_CNT_CTL, 8'h01);
    rd(IDX_CNT_LO, 8'h03);
    wr(IDX_CNT_CTL, 8'h06);
    zrun(9);
    cyc(120);
    rd(IDX_CNT_LO, 8'h04);
    note("zero runs");
    wr(IDX_EVENT_IE, 8'h00);
    wr(IDX_EVENT_IS, 8'hff);
    for (int k = 0; k < 4; k++) begin
      @(posedge aclk);
      ev[k] <= 1'b1;
      @(posedge aclk);
      ev <= 4'h0;
      cyc(2);
      chk("irq", 32'(irq), 32'h0);
      rd(IDX_EVENT_IS, evb[k]);
      wr(IDX_EVENT_IE, evb[k]);
      chk("irq", 32'(irq), 32'h1);
      wr(IDX_EVENT_IS, evb[k]);
      chk("irq", 32'(irq), 32'h0);
    end
    note("event interrupts");
    wr(IDX_CNT_CTL, 8'h40);
    tx(1'b1);
    chk("violation", 32'(tviol), 32'h1);
    tx(1'b1);
    chk("violation", 32'(tviol), 32'h0);
    wr(IDX_CNT_CTL, 8'h40);
    tx(1'b1);
    chk("violation", 32'(tviol), 32'h0);
    wr(IDX_CNT_CTL, 8'h00);
    wr(IDX_CNT_CTL, 8'h40);
    tx(1'b1);
    chk("violation", 32'(tviol), 32'h1);
    note("violation insert");
    test_done();
  end
endmodule
`default_nettype wire
